// *** rtl/srt_pkg.sv ***
// constants for the supervisor reset timeout block
// assumes a 100 MHz system clock standing in for the internal oscillator
package srt_pkg;
   localparam int unsigned CLK_FREQ_HZ     = 100000000;
   localparam int unsigned SHORT_TIMEOUT_MS = 15;
   localparam int unsigned LONG_TIMEOUT_MS  = 200;
   localparam int unsigned SHORT_TIMEOUT_CYC = SHORT_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
   localparam int unsigned LONG_TIMEOUT_CYC  = LONG_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
   localparam int unsigned TIMER_WIDTH      = 25;
   localparam logic        RESET_OUT_RST    = 1'b0;
endpackage

// *** rtl/srt_reset_timeout.sv ***
// reset timeout logic of a voltage supervisor: combines the level comparator
// result with a manual reset and releases reset after a selected timeout.
// assumes all inputs are asynchronous pins; clk_sys_i models the oscillator.
`timescale 1ns/1ps

// two-flop synchroniser for one pin
// the reset value sets what the logic believes before the first real sample
module srt_sync2
   import srt_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk_sys_i, // sampling clock
   input  wire logic reset_i,   // async reset, active high
   input  wire logic async_i,   // pin level, any timing
   output logic      sync_o     // level in the clock domain
);
   logic [1:0] stage_ff;

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         stage_ff <= {2{RST_VAL}};
      end else begin
         stage_ff <= {stage_ff[0], async_i};
      end
   end

   // only the second stage is read, the first may be metastable
   assign sync_o = stage_ff[1];
endmodule

// reset timeout core
// every pin goes through its own synchroniser, so a condition change
// is seen two clocks late; the timer does not absorb that, so release lands at period + 2
module srt_reset_timeout
   import srt_pkg::*;
#(
   parameter bit          HAS_SELECT = 1'b1,
   parameter int unsigned SHORT_CYC  = SHORT_TIMEOUT_CYC,
   parameter int unsigned LONG_CYC   = LONG_TIMEOUT_CYC
) (
   input  wire logic clk_sys_i,             // oscillator clock
   input  wire logic reset_i,               // async reset, active high
   input  wire logic monitored_level_in_i,  // comparator: level above threshold (hyst applied)
   input  wire logic manual_reset_n_i,      // manual reset, low active, pulled up
   input  wire logic timeout_select_i,      // 0 short, 1 long
   input  wire logic uvlo_i,                // supply under lockout threshold
   output logic      reset_n_o              // reset output, low active
);
   typedef enum logic [1:0] {
      SRT_HOLD     = 2'b00, // conditions not met, count cleared
      SRT_COUNT    = 2'b01, // conditions met, timeout running
      SRT_RELEASED = 2'b10  // timeout elapsed, output high
   } srt_state_e;

   // synchronised pin levels
   wire logic level_good;
   wire logic man_rst_released;
   wire logic sel_long;
   wire logic uvlo_active;

   // timer and state
   srt_state_e             state_ff;
   srt_state_e             nxt_state;
   logic [TIMER_WIDTH-1:0] count_ff;
   logic [TIMER_WIDTH-1:0] nxt_count;
   logic                   reset_n_ff;
   logic                   nxt_reset_n;

   // decode
   wire logic [TIMER_WIDTH-1:0] short_cyc;
   wire logic [TIMER_WIDTH-1:0] long_cyc;
   wire logic [TIMER_WIDTH-1:0] period_cyc;
   wire logic [TIMER_WIDTH-1:0] period_last;
   wire logic [TIMER_WIDTH-1:0] count_inc;
   wire logic                   use_short;
   wire logic                   release_ok;
   wire logic                   period_done;

   // level resets to below threshold so nothing releases before a real sample
   srt_sync2 #(
      .RST_VAL (1'b0)
   ) level_sync_u (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .async_i   (monitored_level_in_i),
      .sync_o    (level_good)
   );

   // pull-up lives at the pin; the synchroniser starts at the released level
   srt_sync2 #(
      .RST_VAL (1'b1)
   ) man_rst_sync_u (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .async_i   (manual_reset_n_i),
      .sync_o    (man_rst_released)
   );

   // select is a strap; it is still synchronised since it is a pin
   srt_sync2 #(
      .RST_VAL (1'b1)
   ) sel_sync_u (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .async_i   (timeout_select_i),
      .sync_o    (sel_long)
   );

   // lockout assumed active until the supply has been sampled good
   srt_sync2 #(
      .RST_VAL (1'b1)
   ) uvlo_sync_u (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .async_i   (uvlo_i),
      .sync_o    (uvlo_active)
   );

   // variant without select pin always takes the long period
   assign use_short   = HAS_SELECT && !sel_long;
   assign short_cyc   = TIMER_WIDTH'(SHORT_CYC);
   assign long_cyc    = TIMER_WIDTH'(LONG_CYC);
   assign period_cyc  = use_short ? short_cyc : long_cyc;
   assign period_last = period_cyc - TIMER_WIDTH'(1);
   assign period_done = (count_ff >= period_last);
   assign count_inc   = count_ff + TIMER_WIDTH'(1);
   assign release_ok  = level_good && man_rst_released && !uvlo_active;

   // a select change mid-count takes effect at once; the strap is not
   // expected to move while the device runs
   always_comb begin
      nxt_state = state_ff;
      nxt_count = count_ff;
      if (!release_ok) begin
         nxt_state = SRT_HOLD;
         nxt_count = '0;
      end else begin
         unique case (state_ff)
            SRT_HOLD, SRT_COUNT: begin
               if (period_done) begin
                  nxt_state = SRT_RELEASED;
               end else begin
                  nxt_state = SRT_COUNT;
                  nxt_count = count_inc;
               end
            end
            SRT_RELEASED: begin
               nxt_state = SRT_RELEASED;
            end
            default: begin
               // unused code: fall back to holding reset
               nxt_state = SRT_HOLD;
               nxt_count = '0;
            end
         endcase
      end
   end

   assign nxt_reset_n = (nxt_state == SRT_RELEASED);

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff   <= SRT_HOLD;
         count_ff   <= '0;
         reset_n_ff <= RESET_OUT_RST;
      end else begin
         state_ff   <= nxt_state;
         count_ff   <= nxt_count;
         reset_n_ff <= nxt_reset_n;
      end
   end

   // lockout acts on the output directly so it does not wait on the timer;
   // both terms are flops, so the gate adds no decode glitch
   assign reset_n_o = reset_n_ff && !uvlo_active;
endmodule

// *** tb/srt_button.sv ***
// pushbutton model on the manual reset pin
// assumes the pin idles high through its pull-up
`timescale 1ns/1ps
module srt_button (
   input  wire logic pressed_i,   // switch closed
   output wire logic man_rst_n_o  // pin level, pull-up when open
);
   assign man_rst_n_o = pressed_i ? 1'b0 : 1'b1;
endmodule

// *** tb/srt_reset_timeout_asserts.sv ***
// checker of reset output timing
// assumes bind onto srt_reset_timeout
`timescale 1ns/1ps
module srt_reset_timeout_chk #(
   parameter bit HAS_SELECT = 1'b1,
   parameter int SHORT_CYC  = 20,
   parameter int LONG_CYC   = 50
) (
   input wire logic clk_sys_i,            // design clock
   input wire logic reset_i,              // async reset, active high
   input wire logic monitored_level_in_i, // level good
   input wire logic manual_reset_n_i,     // manual reset pin
   input wire logic timeout_select_i,     // period select pin
   input wire logic uvlo_i,               // lockout
   input wire logic reset_n_o             // design reset output
);
   int cnt_ff;
   wire ok = monitored_level_in_i & manual_reset_n_i & !uvlo_i;
   // variants without select always run the long period
   wire long_sel = timeout_select_i | !HAS_SELECT;
   always_ff @(posedge clk_sys_i or posedge reset_i)
      if (reset_i) cnt_ff <= 0;
      else cnt_ff <= ok ? cnt_ff + 1 : 0;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   chk_man_low: assert property (!manual_reset_n_i [*4] |-> !reset_n_o) else $error("man");
   chk_lvl_low: assert property (!monitored_level_in_i [*4] |-> !reset_n_o) else $error("lv");
   chk_uvlo_low: assert property (uvlo_i [*3] |-> !reset_n_o) else $error("uv");
   chk_short_wait: assert property ($rose(reset_n_o) |-> cnt_ff > SHORT_CYC) else $error("s");
   chk_long_wait: assert property ($rose(reset_n_o) && long_sel |-> cnt_ff > LONG_CYC)
      else $error("l");
   chk_short_end: assert property (cnt_ff == SHORT_CYC + 6 && !long_sel |-> reset_n_o)
      else $error("se");
   chk_long_end: assert property (cnt_ff == LONG_CYC + 6 |-> reset_n_o) else $error("le");
   chk_stays_high: assert property (reset_n_o && cnt_ff > 3 |=> reset_n_o) else $error("h");
   cover property ($rose(reset_n_o));
   cover property (uvlo_i);
   cover property ($rose(manual_reset_n_i));
endmodule
bind srt_reset_timeout srt_reset_timeout_chk #(
   .HAS_SELECT (HAS_SELECT),
   .SHORT_CYC  (SHORT_CYC),
   .LONG_CYC   (LONG_CYC)
) chk_u (
   .clk_sys_i            (clk_sys_i),
   .reset_i              (reset_i),
   .monitored_level_in_i (monitored_level_in_i),
   .manual_reset_n_i     (manual_reset_n_i),
   .timeout_select_i     (timeout_select_i),
   .uvlo_i               (uvlo_i),
   .reset_n_o            (reset_n_o)
);

// *** tb/srt_reset_timeout_tb_top.sv ***
// random timeout runs with restarts and condition losses
// assumes periods shrunk to 20 and 50 cycles
`timescale 1ns/1ps
module srt_reset_timeout_tb_top;
   localparam int SHORT_SIM = 20;
   localparam int LONG_SIM  = 50;
   logic clk_sys_i = 1'b0, reset_i = 1'b1, lvl = 1'b0, press = 1'b0, sel = 1'b0, uvlo = 1'b0;
   wire logic man_rst_n, rst_n, rst_fix_n;
   int miscompares = 0, total_checks = 0, k, p;
   srt_button btn_u (.pressed_i(press), .man_rst_n_o(man_rst_n));
   srt_reset_timeout #(.SHORT_CYC(SHORT_SIM), .LONG_CYC(LONG_SIM)) dut_u (.clk_sys_i(clk_sys_i),
      .reset_i(reset_i), .monitored_level_in_i(lvl), .manual_reset_n_i(man_rst_n),
      .timeout_select_i(sel), .uvlo_i(uvlo), .reset_n_o(rst_n));
   // fixed-period variant shares every input; its select pin must be ignored
   srt_reset_timeout #(.HAS_SELECT(1'b0), .SHORT_CYC(SHORT_SIM), .LONG_CYC(LONG_SIM)) dut_fix_u (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .monitored_level_in_i(lvl),
      .manual_reset_n_i(man_rst_n), .timeout_select_i(sel), .uvlo_i(uvlo),
      .reset_n_o(rst_fix_n));
   function automatic int exp_period(logic s, bit has_sel);
      return (has_sel && (s == 1'b0)) ? SHORT_SIM : LONG_SIM;
   endfunction
   task automatic cmp(input logic act, input logic exp);
      total_checks++;
      if (act !== exp) begin
         miscompares++;
         $display("[ERR] %0t %h %h", $time, act, exp);
      end
   endtask
   task automatic w(int n); repeat (n) @(negedge clk_sys_i); endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial forever #5 clk_sys_i = ~clk_sys_i;
   initial begin #200000 miscompares++; tally_and_finish(); end
   initial begin
      k = $urandom(86);
      w(12); reset_i = 0;
      for (k = 0; k < 20; k++) begin
         sel = 1'($urandom); lvl = 1'b1; press = 1'b0; uvlo = 1'b0;
         if (k % 3 == 1) begin
            w(7);
            cmp(rst_n, 1'b0);
            press = 1'b1;
            w(1);
            press = 1'b0;
         end
         // the two sync stages alone put the edge at period + 2
         p = exp_period(sel, 1'b1);
         w(p + 1);
         cmp(rst_n, 1'b0);
         w(1);
         cmp(rst_n, 1'b1);
         if (p < LONG_SIM) begin
            cmp(rst_fix_n, 1'b0);
            w(LONG_SIM - p - 1);
            cmp(rst_fix_n, 1'b0);
            w(1);
         end
         cmp(rst_fix_n, 1'b1);
         case ($urandom % 3) 0: lvl = 1'b0; 1: press = 1'b1; default: uvlo = 1'b1; endcase
         w(4);
         cmp(rst_n, 1'b0);
         cmp(rst_fix_n, 1'b0);
      end
      tally_and_finish();
   end
endmodule
